// *** core/cmw_pkg.sv ***
// Package: register map, field layout and carrier types of the message status block
package cmw_pkg;

    // ****************************************************************
    // Register byte offsets
    // ****************************************************************
    localparam logic [11:0] OFS_TX_REQ_HIGH  = 12'h104;
    localparam logic [11:0] OFS_NEW_DAT_LOW  = 12'h120;
    localparam logic [11:0] OFS_NEW_DAT_HIGH = 12'h124;
    localparam logic [11:0] OFS_IRQ_PND_LOW  = 12'h140;
    localparam logic [11:0] OFS_IRQ_PND_HIGH = 12'h144;
    localparam logic [11:0] OFS_VALID_LOW    = 12'h160;
    localparam logic [11:0] OFS_VALID_HIGH   = 12'h164;
    localparam logic [11:0] OFS_WAKE_ENABLE  = 12'h168;
    localparam logic [11:0] OFS_WAKE_STATUS  = 12'h16C;

    // ****************************************************************
    // Fields and reset values
    // ****************************************************************
    localparam int          HALF_W          = 16;
    localparam int          WAKE_BIT        = 0;
    localparam logic [31:0] RST_FLAGS       = 32'h0000_0000;
    localparam logic        RST_WAKE        = 1'h0;
    localparam logic [7:0]  ID_NONE         = 8'h00;
    // Identifier shown while the core reports a status interrupt
    localparam logic [7:0]  ID_STATUS       = 8'hFF;
    localparam logic [1:0]  RESP_OKAY       = 2'h0;
    localparam logic [1:0]  RESP_DECERR     = 2'h3;

    // ****************************************************************
    // Carrier types
    // ****************************************************************
    typedef struct packed {
        logic object_valid_flag;
        logic transmit_pending_flag;
        logic fresh_data_flag;
        logic object_irq_flag;
    } cmw_obj_flags_s;

    typedef struct packed {
        logic [31:0] transmit_pending_flag;
        logic [31:0] fresh_data_flag;
        logic [31:0] object_irq_flag;
        logic [31:0] object_valid_flag;
    } cmw_flag_bank_s;

    typedef struct packed {
        cmw_flag_bank_s flags;
        logic [7:0]     interrupt_identifier;
        logic           wakeup_enable;
        logic           wakeup_event_status;
        logic           rx_sync1;
        logic           rx_sync2;
        logic           rx_prev;
        logic           aw_held;
        logic           w_held;
        logic [11:0]    aw_addr;
        logic [31:0]    w_data;
        logic [3:0]     w_strb;
        logic           b_valid;
        logic [1:0]     b_resp;
        logic           r_valid;
        logic [31:0]    r_data;
        logic [1:0]     r_resp;
        logic           aw_ready;
        logic           w_ready;
        logic           ar_ready;
    } cmw_state_s;

endpackage

// *** core/cmw_status.sv ***
// Message object status registers and wake-up detector with an AXI4-Lite slave
//
// Operation
// - TX request high: objects 17-32, read only
// - TX flag 1 while transmit still pending
// - Handler receive or interface sets new-data
// - New-data low 1-16, high 17-32
// - New-data 1 after write, 0 after clear
// - IRQ flag set by handler, updates identifier
// - IRQ pending low 1-16, high 17-32
// - Handler ignores objects whose valid flag is 0
// - Valid low bit 0 is object 1
// - Valid high bit 15 is object 32
// - Wake enable bit 0, read/write, reset 0
// - Enabled: CAN receive falling edge wakes
// - Wake status bit 0 shows event occurred
// - Writing 0 clears wake status
// - Remote frame sets TX flag, transmission clears
// - Identifier names pending object when nothing higher
// - All handler status registers read only
//
// Decided for this implementation: the AXI4-Lite register port.
`timescale 1ns/1ns
module cmw_status #(
    parameter int ADDR_W = 12
) (
    // Clock and reset
    input  wire logic                    CLK,
    input  wire logic                    RST_N,
    // AXI4-Lite write address and data
    input  wire logic [ADDR_W-1:0]       AWADDR,
    input  wire logic                    AWVALID,
    output logic                         AWREADY,
    input  wire logic [31:0]             WDATA,
    input  wire logic [3:0]              WSTRB,
    input  wire logic                    WVALID,
    output logic                         WREADY,
    // AXI4-Lite write response
    output logic [1:0]                   BRESP,
    output logic                         BVALID,
    input  wire logic                    BREADY,
    // AXI4-Lite read
    input  wire logic [ADDR_W-1:0]       ARADDR,
    input  wire logic                    ARVALID,
    output logic                         ARREADY,
    output logic [31:0]                  RDATA,
    output logic [1:0]                   RRESP,
    output logic                         RVALID,
    input  wire logic                    RREADY,
    // Message handler events, one bit per object, and a single status interrupt
    input  wire logic [31:0]             RX_DATA_DONE,
    input  wire logic [31:0]             RX_REMOTE_DONE,
    input  wire logic [31:0]             TX_DONE,
    input  wire logic                    STATUS_IRQ,
    // Message interface set write
    input  wire logic                    IF_WRITE,
    input  wire logic [4:0]              IF_OBJECT,
    input  wire cmw_pkg::cmw_obj_flags_s IF_FLAGS,
    // CAN receive pin
    input  wire logic                    CAN_RX,
    // Status towards the handler and system
    output logic [31:0]                  TX_PENDING,
    output logic [31:0]                  OBJ_VALID,
    output logic [7:0]                   INT_ID,
    output logic                         WAKEUP
);

    // ****************************************************************
    // State
    // ****************************************************************
    cmw_pkg::cmw_state_s st_reg;
    cmw_pkg::cmw_state_s st_next;

    logic                wake_fall;
    logic                wake_clear;
    logic                wr_fire;
    logic [31:0]         hs_data;
    logic [31:0]         hs_remote;
    logic [31:0]         hs_tx;

    assign wake_fall  = st_reg.rx_prev & ~st_reg.rx_sync2;
    assign wr_fire    = st_reg.aw_held & st_reg.w_held & ~st_reg.b_valid;
    assign wake_clear = wr_fire && st_reg.aw_addr == cmw_pkg::OFS_WAKE_STATUS
                        && st_reg.w_strb[0] && !st_reg.w_data[cmw_pkg::WAKE_BIT];
    // Handler events only count for configured objects
    assign hs_data    = RX_DATA_DONE & st_reg.flags.object_valid_flag;
    assign hs_remote  = RX_REMOTE_DONE & st_reg.flags.object_valid_flag;
    assign hs_tx      = TX_DONE & st_reg.flags.object_valid_flag;

    // ****************************************************************
    // Read decode
    // ****************************************************************
    function automatic logic [32:0] read_word(input cmw_pkg::cmw_state_s s,
                                              input logic [11:0] a);
        logic [32:0] r;
        r = {1'b1, 32'h0000_0000};
        case (a)
            cmw_pkg::OFS_TX_REQ_HIGH:
                r = {1'b1, 16'h0000, s.flags.transmit_pending_flag[31:16]};
            cmw_pkg::OFS_NEW_DAT_LOW:
                r = {1'b1, 16'h0000, s.flags.fresh_data_flag[15:0]};
            cmw_pkg::OFS_NEW_DAT_HIGH:
                r = {1'b1, 16'h0000, s.flags.fresh_data_flag[31:16]};
            cmw_pkg::OFS_IRQ_PND_LOW:
                r = {1'b1, 16'h0000, s.flags.object_irq_flag[15:0]};
            cmw_pkg::OFS_IRQ_PND_HIGH:
                r = {1'b1, 16'h0000, s.flags.object_irq_flag[31:16]};
            cmw_pkg::OFS_VALID_LOW:
                r = {1'b1, 16'h0000, s.flags.object_valid_flag[15:0]};
            cmw_pkg::OFS_VALID_HIGH:
                r = {1'b1, 16'h0000, s.flags.object_valid_flag[31:16]};
            cmw_pkg::OFS_WAKE_ENABLE:
                r = {1'b1, 31'h0000_0000, s.wakeup_enable};
            cmw_pkg::OFS_WAKE_STATUS:
                r = {1'b1, 31'h0000_0000, s.wakeup_event_status};
            default:
                r = {1'b0, 32'h0000_0000};
        endcase
        return r;
    endfunction

    function automatic logic mapped(input logic [11:0] a);
        return read_word(st_reg, a) >> 32 != 33'h0_0000_0000;
    endfunction

    // ****************************************************************
    // Next state
    // ****************************************************************
    always_comb begin
        logic [32:0]    rd;
        logic [31:0]    pend;
        cmw_pkg::cmw_flag_bank_s f;
        rd      = 33'h0_0000_0000;
        pend    = 32'h0000_0000;
        f       = st_reg.flags;
        st_next = st_reg;

        // Pin synchroniser and edge history
        st_next.rx_sync1 = CAN_RX;
        st_next.rx_sync2 = st_reg.rx_sync1;
        st_next.rx_prev  = st_reg.rx_sync2;

        // Software view through the message interface
        if (IF_WRITE) begin
            f.object_valid_flag[IF_OBJECT]     = IF_FLAGS.object_valid_flag;
            f.transmit_pending_flag[IF_OBJECT] = IF_FLAGS.transmit_pending_flag;
            f.fresh_data_flag[IF_OBJECT]       = IF_FLAGS.fresh_data_flag;
            f.object_irq_flag[IF_OBJECT]       = IF_FLAGS.object_irq_flag;
        end
        // Completed transmissions clear, handler sets always win
        f.transmit_pending_flag = (f.transmit_pending_flag & ~hs_tx) | hs_remote;
        f.fresh_data_flag       = f.fresh_data_flag | hs_data;
        f.object_irq_flag       = f.object_irq_flag | hs_data | hs_tx;
        st_next.flags           = f;

        // Identifier follows the registered pending flags
        pend = st_reg.flags.object_irq_flag;
        st_next.interrupt_identifier = cmw_pkg::ID_NONE;
        for (int i = 31; i >= 0; i--) begin
            if (pend[i]) begin
                st_next.interrupt_identifier = 8'(i + 1);
            end
        end
        if (STATUS_IRQ) begin
            st_next.interrupt_identifier = cmw_pkg::ID_STATUS;
        end

        // Write channel capture
        if (AWVALID && !st_reg.aw_held && !st_reg.b_valid) begin
            st_next.aw_held = 1'b1;
            st_next.aw_addr = 12'(AWADDR);
        end
        if (WVALID && !st_reg.w_held && !st_reg.b_valid) begin
            st_next.w_held = 1'b1;
            st_next.w_data = WDATA;
            st_next.w_strb = WSTRB;
        end
        if (wr_fire) begin
            st_next.aw_held = 1'b0;
            st_next.w_held  = 1'b0;
            st_next.b_valid = 1'b1;
            st_next.b_resp  = mapped(st_reg.aw_addr) ? cmw_pkg::RESP_OKAY
                                                     : cmw_pkg::RESP_DECERR;
            // Status registers ignore writes
            if (st_reg.aw_addr == cmw_pkg::OFS_WAKE_ENABLE && st_reg.w_strb[0]) begin
                st_next.wakeup_enable = st_reg.w_data[cmw_pkg::WAKE_BIT];
            end
        end
        if (st_reg.b_valid && BREADY) begin
            st_next.b_valid = 1'b0;
        end

        // Wake status: clear by writing 0, a new event wins
        if (wake_clear) begin
            st_next.wakeup_event_status = 1'b0;
        end
        if (st_reg.wakeup_enable && wake_fall) begin
            st_next.wakeup_event_status = 1'b1;
        end

        // Read channel
        if (ARVALID && !st_reg.r_valid) begin
            rd              = read_word(st_reg, 12'(ARADDR));
            st_next.r_valid = 1'b1;
            st_next.r_data  = rd[31:0];
            st_next.r_resp  = rd[32] ? cmw_pkg::RESP_OKAY : cmw_pkg::RESP_DECERR;
        end else if (st_reg.r_valid && RREADY) begin
            st_next.r_valid = 1'b0;
        end

        // Ready flags registered from the next channel state
        st_next.aw_ready = ~st_next.aw_held & ~st_next.b_valid;
        st_next.w_ready  = ~st_next.w_held & ~st_next.b_valid;
        st_next.ar_ready = ~st_next.r_valid;
    end

    always_ff @(posedge CLK) begin
        if (!RST_N) begin
            st_reg                     <= '0;
            st_reg.flags               <= {4{cmw_pkg::RST_FLAGS}};
            st_reg.wakeup_enable       <= cmw_pkg::RST_WAKE;
            st_reg.wakeup_event_status <= cmw_pkg::RST_WAKE;
            st_reg.rx_sync1            <= 1'b1;
            st_reg.rx_sync2            <= 1'b1;
            st_reg.rx_prev             <= 1'b1;
            st_reg.aw_ready            <= 1'b1;
            st_reg.w_ready             <= 1'b1;
            st_reg.ar_ready            <= 1'b1;
        end else begin
            st_reg <= st_next;
        end
    end

    // ****************************************************************
    // Outputs
    // ****************************************************************
    assign AWREADY    = st_reg.aw_ready;
    assign WREADY     = st_reg.w_ready;
    assign BVALID     = st_reg.b_valid;
    assign BRESP      = st_reg.b_resp;
    assign ARREADY    = st_reg.ar_ready;
    assign RVALID     = st_reg.r_valid;
    assign RDATA      = st_reg.r_data;
    assign RRESP      = st_reg.r_resp;
    assign TX_PENDING = st_reg.flags.transmit_pending_flag;
    assign OBJ_VALID  = st_reg.flags.object_valid_flag;
    assign INT_ID     = st_reg.interrupt_identifier;
    assign WAKEUP     = st_reg.wakeup_event_status;

    // ****************************************************************
    // Assertions
    // ****************************************************************
    default clocking cb @(posedge CLK);
    endclocking
    default disable iff (!RST_N);

    a_remote_sets_tx: assert property ((hs_remote[0]) |=> TX_PENDING[0])
        else $error("remote frame did not set transmit flag");
    a_tx_done_clears: assert property ((hs_tx[3] && !hs_remote[3] && !IF_WRITE)
        |=> !TX_PENDING[3])
        else $error("transmit flag stayed after completion");
    a_invalid_ignored: assert property ((!OBJ_VALID[5] && RX_DATA_DONE[5] && !IF_WRITE
        && !st_reg.flags.fresh_data_flag[5]) |=> !st_reg.flags.fresh_data_flag[5])
        else $error("invalid object accepted data");
    a_data_sets_new: assert property ((hs_data[20]) |=> st_reg.flags.fresh_data_flag[20]
        && st_reg.flags.object_irq_flag[20])
        else $error("received data did not set flags");
    a_irq_id_first: assert property ((st_reg.flags.object_irq_flag[0] && !STATUS_IRQ)
        |=> INT_ID == 8'h01)
        else $error("identifier does not name object 1");
    a_wake_event: assert property ((st_reg.wakeup_enable && wake_fall) |=> WAKEUP)
        else $error("wake event missed");
    a_wake_sticks: assert property ((WAKEUP && !wake_clear) |=> WAKEUP)
        else $error("wake status dropped without clear");
    a_wake_disabled: assert property ((!WAKEUP && !st_reg.wakeup_enable) |=> !WAKEUP)
        else $error("wake status set while disabled");
    a_wake_clear: assert property ((wake_clear && !(st_reg.wakeup_enable && wake_fall))
        |=> !WAKEUP)
        else $error("wake status not cleared");
    a_rsvd_zero: assert property ((RVALID) |-> RDATA[31:16] == 16'h0000)
        else $error("reserved read bits not zero");
    a_write_resp: assert property ((AWVALID && AWREADY && WVALID && WREADY)
        |=> !BVALID ##1 BVALID)
        else $error("write response timing wrong");
    a_valid_bus_ro: assert property ((wr_fire && !IF_WRITE) |=> $stable(OBJ_VALID))
        else $error("bus write changed valid flags");
    a_enable_set: assert property ((wr_fire && st_reg.aw_addr == cmw_pkg::OFS_WAKE_ENABLE
        && st_reg.w_strb[0] && st_reg.w_data[cmw_pkg::WAKE_BIT]) |=> st_reg.wakeup_enable)
        else $error("wake enable write lost");
    a_id_none: assert property ((st_reg.flags.object_irq_flag == 32'h0000_0000 && !STATUS_IRQ)
        |=> INT_ID == cmw_pkg::ID_NONE)
        else $error("identifier set with nothing pending");

endmodule

// *** test/cmw_can_node.sv ***
// Partner model: another node on the CAN bus driving the receive line
`timescale 1ns/1ns
module cmw_can_node #(
    parameter int BIT_NS = 400
) (
    // Bus level seen at the receive pin
    output logic can_rx
);
    // Recessive high between frames
    initial begin
        can_rx = 1'b1;
    end
    // Dominant for some bit times, then back to recessive
    task automatic send_dominant(input int nbits);
        can_rx = 1'b0;
        #(nbits * BIT_NS);
        can_rx = 1'b1;
        #(BIT_NS);
    endtask
endmodule

// *** test/tb_cmw_status.sv ***
// Testbench: flag registers, identifier, read-only map and wake-up of the status block
`timescale 1ns/1ns
module tb_cmw_status;
    logic        clk, rst_n, awvalid, wvalid, bready, arvalid, rready, awready, wready;
    logic        bvalid, arready, rvalid, status_irq, if_write, can_rx, wakeup;
    logic [11:0] awaddr, araddr;
    logic [31:0] wdata, rdata, rx_data_done, rx_remote_done, tx_done, tx_pending, obj_valid;
    logic [31:0] m_tx, m_nd, m_irq, m_vld, rd;
    logic [3:0]  wstrb;
    logic [1:0]  bresp, rresp, rsp;
    logic [4:0]  if_object;
    logic [7:0]  int_id;
    cmw_pkg::cmw_obj_flags_s if_flags, fl;
    int          err_count, check_count, seed, i;

    cmw_status cmw_status_inst (.CLK(clk), .RST_N(rst_n), .AWADDR(awaddr), .AWVALID(awvalid),
        .AWREADY(awready), .WDATA(wdata), .WSTRB(wstrb), .WVALID(wvalid), .WREADY(wready),
        .BRESP(bresp), .BVALID(bvalid), .BREADY(bready), .ARADDR(araddr), .ARVALID(arvalid),
        .ARREADY(arready), .RDATA(rdata), .RRESP(rresp), .RVALID(rvalid), .RREADY(rready),
        .RX_DATA_DONE(rx_data_done), .RX_REMOTE_DONE(rx_remote_done), .TX_DONE(tx_done),
        .STATUS_IRQ(status_irq), .IF_WRITE(if_write), .IF_OBJECT(if_object),
        .IF_FLAGS(if_flags), .CAN_RX(can_rx), .TX_PENDING(tx_pending),
        .OBJ_VALID(obj_valid), .INT_ID(int_id), .WAKEUP(wakeup));
    cmw_can_node cmw_can_node_inst (.can_rx(can_rx));

    // ****************************************************************
    // Clock, watchdog and reporting
    // ****************************************************************
    initial begin
        clk = 1'b0;
        forever #20 clk = ~clk;
    end
    initial begin
        #400000;
        err_count++;
        final_report;
    end
    task automatic final_report;
        $display("checks %0d mismatches %0d", check_count, err_count);
        if (err_count == 0 && check_count > 0) $display("Regression OK");
        else $display("Regression broken");
        $finish;
    endtask
    task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
        check_count++;
        if (seen !== exp) begin
            err_count++;
            $display("[ERR] %s expected %h seen %h", nm, exp, seen);
        end
    endtask
    function automatic logic [7:0] exp_id(input logic [31:0] p);
        exp_id = 8'h00;
        for (int k = 31; k >= 0; k--) if (p[k]) exp_id = 8'(k + 1);
    endfunction
    function automatic logic [11:0] ro_ofs(input int k);
        case (k)
            1: ro_ofs = cmw_pkg::OFS_NEW_DAT_LOW;
            2: ro_ofs = cmw_pkg::OFS_NEW_DAT_HIGH;
            3: ro_ofs = cmw_pkg::OFS_IRQ_PND_LOW;
            4: ro_ofs = cmw_pkg::OFS_IRQ_PND_HIGH;
            5: ro_ofs = cmw_pkg::OFS_VALID_LOW;
            6: ro_ofs = cmw_pkg::OFS_VALID_HIGH;
            default: ro_ofs = cmw_pkg::OFS_TX_REQ_HIGH;
        endcase
    endfunction

    // ****************************************************************
    // Bus master and handler drivers
    // ****************************************************************
    task automatic axi_write(input logic [11:0] a, input logic [31:0] d, output logic [1:0] r);
        logic ah, wh, bh;
        @(posedge clk);
        awaddr <= a;
        awvalid <= 1'b1;
        wdata <= d;
        wstrb <= 4'hF;
        wvalid <= 1'b1;
        bready <= 1'b1;
        bh = 1'b0;
        while (!bh) begin
            @(negedge clk);
            ah = awvalid && awready;
            wh = wvalid && wready;
            bh = bvalid;
            r = bresp;
            @(posedge clk);
            if (ah) awvalid <= 1'b0;
            if (wh) wvalid <= 1'b0;
        end
        bready <= 1'b0;
    endtask
    task automatic axi_read(input logic [11:0] a, output logic [31:0] d, output logic [1:0] r);
        logic ah, rh;
        @(posedge clk);
        araddr <= a;
        arvalid <= 1'b1;
        rready <= 1'b1;
        rh = 1'b0;
        while (!rh) begin
            @(negedge clk);
            ah = arvalid && arready;
            rh = rvalid;
            d = rdata;
            r = rresp;
            @(posedge clk);
            if (ah) arvalid <= 1'b0;
        end
        rready <= 1'b0;
    endtask
    task automatic rdc(input logic [11:0] a, input logic [31:0] e, input string nm);
        axi_read(a, rd, rsp);
        chk(nm, rd, e);
    endtask
    task automatic ev(input logic [31:0] rx, input logic [31:0] rm, input logic [31:0] tx);
        @(posedge clk);
        rx_data_done <= rx;
        rx_remote_done <= rm;
        tx_done <= tx;
        @(posedge clk);
        rx_data_done <= '0;
        rx_remote_done <= '0;
        tx_done <= '0;
        m_nd = m_nd | (rx & m_vld);
        m_irq = m_irq | ((rx | tx) & m_vld);
        m_tx = (m_tx & ~(tx & m_vld)) | (rm & m_vld);
    endtask
    task automatic if_wr(input logic [4:0] o, input cmw_pkg::cmw_obj_flags_s f);
        @(posedge clk);
        if_write <= 1'b1;
        if_object <= o;
        if_flags <= f;
        @(posedge clk);
        if_write <= 1'b0;
        m_vld[o] = f.object_valid_flag;
        m_tx[o] = f.transmit_pending_flag;
        m_nd[o] = f.fresh_data_flag;
        m_irq[o] = f.object_irq_flag;
    endtask
    task automatic check_bank;
        rdc(cmw_pkg::OFS_TX_REQ_HIGH, {16'h0, m_tx[31:16]}, "tx_high");
        rdc(cmw_pkg::OFS_NEW_DAT_LOW, {16'h0, m_nd[15:0]}, "nd_low");
        rdc(cmw_pkg::OFS_NEW_DAT_HIGH, {16'h0, m_nd[31:16]}, "nd_high");
        rdc(cmw_pkg::OFS_IRQ_PND_LOW, {16'h0, m_irq[15:0]}, "irq_low");
        rdc(cmw_pkg::OFS_IRQ_PND_HIGH, {16'h0, m_irq[31:16]}, "irq_high");
        rdc(cmw_pkg::OFS_VALID_LOW, {16'h0, m_vld[15:0]}, "valid_low");
        rdc(cmw_pkg::OFS_VALID_HIGH, {16'h0, m_vld[31:16]}, "valid_high");
        chk("tx_port", tx_pending, m_tx);
        chk("valid_port", obj_valid, m_vld);
        chk("int_id", {24'h0, int_id}, {24'h0, exp_id(m_irq)});
    endtask

    // ****************************************************************
    // Main sequence
    // ****************************************************************
    initial begin
        seed = 32'h940E;
        {rst_n, awvalid, wvalid, bready, arvalid, rready, status_irq, if_write} = '0;
        {awaddr, araddr, wdata, wstrb, if_object} = '0;
        {rx_data_done, rx_remote_done, tx_done, m_tx, m_nd, m_irq, m_vld} = '0;
        if_flags = '0;
        err_count = 0;
        check_count = 0;
        repeat (4) @(posedge clk);
        rst_n <= 1'b1;
        check_bank;
        rdc(cmw_pkg::OFS_WAKE_ENABLE, 32'h0, "wake_en_rst");
        rdc(cmw_pkg::OFS_WAKE_STATUS, 32'h0, "wake_sts_rst");
        rdc(12'h200, 32'h0, "unmapped_data");
        chk("unmapped_resp", {30'h0, rsp}, {30'h0, cmw_pkg::RESP_DECERR});
        $display("test reset done");
        for (i = 0; i < 12; i++) begin
            fl = 4'($random(seed));
            if_wr((i == 0) ? 5'h00 : (i == 1) ? 5'h1F : 5'($random(seed)), fl);
            if (i % 3 == 2) check_bank;
        end
        $display("test interface writes done");
        for (i = 0; i < 16; i++) begin
            if (i == 0) ev(32'h0, m_vld, m_vld);
            else ev($random(seed) & $random(seed), $random(seed) & $random(seed),
                    $random(seed) & $random(seed));
            if (i % 4 == 3) check_bank;
        end
        @(posedge clk);
        status_irq <= 1'b1;
        repeat (3) @(posedge clk);
        @(negedge clk);
        chk("int_id_status", {24'h0, int_id}, {24'h0, cmw_pkg::ID_STATUS});
        @(posedge clk);
        status_irq <= 1'b0;
        $display("test handler events done");
        for (i = 0; i < 7; i++) begin
            axi_write(ro_ofs(i), 32'hFFFF_FFFF, rsp);
            chk("ro_write_resp", {30'h0, rsp}, {30'h0, cmw_pkg::RESP_OKAY});
        end
        check_bank;
        $display("test read only done");
        cmw_can_node_inst.send_dominant(3);
        repeat (4) @(negedge clk);
        chk("wake_disabled", {31'h0, wakeup}, 32'h0);
        axi_write(cmw_pkg::OFS_WAKE_ENABLE, 32'hFFFF_FFFF, rsp);
        rdc(cmw_pkg::OFS_WAKE_ENABLE, 32'h1, "wake_en_rw");
        chk("wake_late_enable", {31'h0, wakeup}, 32'h0);
        cmw_can_node_inst.send_dominant(3);
        repeat (4) @(negedge clk);
        chk("wake_event", {31'h0, wakeup}, 32'h1);
        rdc(cmw_pkg::OFS_WAKE_STATUS, 32'h1, "wake_sts_set");
        axi_write(cmw_pkg::OFS_WAKE_STATUS, 32'hFFFF_FFFF, rsp);
        rdc(cmw_pkg::OFS_WAKE_STATUS, 32'h1, "wake_sts_sticky");
        axi_write(cmw_pkg::OFS_WAKE_STATUS, 32'hFFFF_FFFE, rsp);
        rdc(cmw_pkg::OFS_WAKE_STATUS, 32'h0, "wake_sts_clear");
        chk("wake_port_clear", {31'h0, wakeup}, 32'h0);
        axi_write(cmw_pkg::OFS_WAKE_ENABLE, 32'h0, rsp);
        rdc(cmw_pkg::OFS_WAKE_ENABLE, 32'h0, "wake_en_off");
        cmw_can_node_inst.send_dominant(3);
        repeat (4) @(negedge clk);
        chk("wake_off_event", {31'h0, wakeup}, 32'h0);
        $display("test wake-up done");
        final_report;
    end
endmodule
